// >>> core/gcs_port_bank.sv
// file: port bank global config, direction, debounce, autosleep and fade logic
`timescale 1ns/1ps
module gcs_port_bank #(
    parameter int TICK_CYCLES = gcs_pkg::TICK_MS_CYCLES,
    parameter int PORTS = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register access from the serial engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rd_hit,
    // serial engine and key-scan events
    input wire logic bus_timeout,
    input wire logic key_activity,
    input wire logic key_sleep_bit,
    // pwm side
    input wire logic [7:0] common_pwm,
    input wire logic fade_up,
    output logic [7:0] fade_level,
    output logic pwm_en,
    output logic cc_en,
    output logic full_shutdown,
    output logic key_sleep_req,
    // shared register bank control
    output logic bank_wr_en,
    output logic bank_soft_reset,
    // ports
    input wire logic [PORTS-1:0] general_input_pin,
    input wire logic [PORTS-1:0] port_out_level,
    output logic [PORTS-1:0] general_output_pin,
    output logic [PORTS-1:0] port_dir,
    output logic [PORTS-1:0] port_in_value,
    output logic rotary_mode,
    output logic rotary_input_a,
    output logic rotary_input_b,
    output logic port_interrupt_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [gcs_pkg::SLEEP_CODE_W-1:0] sleep_timeout_select_reg;
    gcs_pkg::gcs_global_s port_bank_global_config_reg;
    logic [PORTS-1:0] port_direction_reg;
    logic [gcs_pkg::DEBOUNCE_W-1:0] port_input_debounce_reg;
    logic timeout_flag_reg;
    logic wr_sleep, wr_global, wr_dir, wr_dbnc, rd_flag, soft_rst;
    logic bank_en;

    assign bank_en = port_bank_global_config_reg.bank_en;
    assign wr_sleep = reg_wr && reg_addr == gcs_pkg::OFS_KEY_SLEEP;
    assign wr_global = reg_wr && reg_addr == gcs_pkg::OFS_GLOBAL;
    // frozen while the bank is off
    assign wr_dir = reg_wr && bank_en && reg_addr == gcs_pkg::OFS_DIRECTION;
    assign wr_dbnc = reg_wr && bank_en && reg_addr == gcs_pkg::OFS_DEBOUNCE;
    assign rd_flag = reg_rd && reg_addr == gcs_pkg::OFS_TIMEOUT_FLAG;
    assign soft_rst = wr_global && reg_wdata[gcs_pkg::BIT_BANK_RESET];

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sleep_timeout_select_reg <= gcs_pkg::RST_SLEEP_CODE;
        end else if (wr_sleep) begin
            // upper bits reserved, kept out of storage
            sleep_timeout_select_reg <= reg_wdata[gcs_pkg::SLEEP_CODE_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || soft_rst) begin
            port_bank_global_config_reg <= gcs_pkg::RST_GLOBAL;
        end else if (wr_global) begin
            port_bank_global_config_reg <= reg_wdata;
            port_bank_global_config_reg.rsvd <= 1'b0;
            port_bank_global_config_reg.bank_reset <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || soft_rst) begin
            port_direction_reg <= gcs_pkg::RST_DIRECTION;
            port_input_debounce_reg <= gcs_pkg::RST_DEBOUNCE;
        end else begin
            if (wr_dir) begin
                port_direction_reg <= reg_wdata[PORTS-1:0];
            end
            if (wr_dbnc) begin
                port_input_debounce_reg <= reg_wdata[gcs_pkg::DEBOUNCE_W-1:0];
            end
        end
    end

    // timeout flag: a new timeout in the read cycle wins over the release
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            timeout_flag_reg <= 1'b0;
        end else if (bus_timeout && port_bank_global_config_reg.to_int_en) begin
            timeout_flag_reg <= 1'b1;
        end else if (rd_flag) begin
            timeout_flag_reg <= 1'b0;
        end
    end

    // read answer one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= 8'h00;
            reg_rd_hit <= 1'b0;
        end else if (reg_rd) begin
            reg_rd_hit <= 1'b1;
            unique case (reg_addr)
                gcs_pkg::OFS_KEY_SLEEP: reg_rdata <= {5'h00, sleep_timeout_select_reg};
                gcs_pkg::OFS_GLOBAL: reg_rdata <= port_bank_global_config_reg;
                gcs_pkg::OFS_DIRECTION: reg_rdata <= port_direction_reg;
                gcs_pkg::OFS_DEBOUNCE: reg_rdata <= {3'h0, port_input_debounce_reg};
                default: begin
                    reg_rdata <= 8'h00;
                    reg_rd_hit <= 1'b0;
                end
            endcase
        end else begin
            reg_rd_hit <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // millisecond tick

    logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_reg;
    logic ms_tick_reg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tick_cnt_reg <= '0;
            ms_tick_reg <= 1'b0;
        end else if (tick_cnt_reg == $bits(tick_cnt_reg)'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
            ms_tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            ms_tick_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // autosleep

    logic [gcs_pkg::MS_CNT_W-1:0] idle_ms_reg;
    logic [gcs_pkg::MS_CNT_W-1:0] sleep_limit;

    // code 7 shares the shortest period with code 6
    always_comb begin
        if (sleep_timeout_select_reg >= gcs_pkg::SLEEP_CODE_MIN) begin
            sleep_limit = gcs_pkg::MS_CNT_W'(gcs_pkg::SLEEP_MIN_MS);
        end else begin
            sleep_limit = gcs_pkg::MS_CNT_W'(gcs_pkg::SLEEP_MAX_MS)
                >> (sleep_timeout_select_reg - 3'h1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            idle_ms_reg <= '0;
            key_sleep_req <= 1'b0;
        end else if (key_activity || sleep_timeout_select_reg == gcs_pkg::SLEEP_CODE_OFF) begin
            idle_ms_reg <= '0;
            key_sleep_req <= 1'b0;
        end else if (ms_tick_reg && !key_sleep_req) begin
            if (idle_ms_reg + 1'b1 >= sleep_limit) begin
                key_sleep_req <= 1'b1;
            end
            idle_ms_reg <= idle_ms_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fade engine

    gcs_pkg::gcs_fade_e fade_state_reg;
    logic [4:0] fade_step_reg;
    logic [gcs_pkg::MS_CNT_W-1:0] fade_ms_reg;
    logic [gcs_pkg::MS_CNT_W-1:0] step_ms;
    logic [2:0] fade_code;
    logic fade_dir_reg;
    logic [12:0] level_prod;

    assign fade_code = port_bank_global_config_reg.fade;
    // 256 ms over 16 steps is 16 ms a step, doubling per code
    assign step_ms = gcs_pkg::MS_CNT_W'(gcs_pkg::FADE_STEP_MIN_MS)
        << (fade_code - 3'h1);
    assign level_prod = common_pwm * fade_step_reg;

    always_ff @(posedge clk_sys) begin
        if (srst || !bank_en || fade_code == gcs_pkg::FADE_CODE_OFF) begin
            fade_state_reg <= gcs_pkg::FADE_IDLE;
            fade_step_reg <= 5'(gcs_pkg::FADE_STEPS);
            fade_ms_reg <= '0;
            fade_dir_reg <= 1'b1;
        end else begin
            unique case (fade_state_reg)
                // full level held, so a low fade_up already means a ramp down
                gcs_pkg::FADE_IDLE: begin
                    fade_state_reg <= gcs_pkg::FADE_HELD;
                end
                gcs_pkg::FADE_HELD: begin
                    if (fade_up != fade_dir_reg) begin
                        fade_dir_reg <= fade_up;
                        fade_ms_reg <= '0;
                        fade_state_reg <= gcs_pkg::FADE_RAMP;
                    end
                end
                gcs_pkg::FADE_RAMP: begin
                    if (fade_up != fade_dir_reg) begin
                        fade_dir_reg <= fade_up;
                        fade_ms_reg <= '0;
                    end else if (ms_tick_reg) begin
                        if (fade_ms_reg + 1'b1 >= step_ms) begin
                            fade_ms_reg <= '0;
                            // one sixteenth of the way per step
                            if (fade_dir_reg) begin
                                fade_step_reg <= fade_step_reg + 5'h1;
                            end else begin
                                fade_step_reg <= fade_step_reg - 5'h1;
                            end
                            if ((fade_dir_reg && fade_step_reg == 5'(gcs_pkg::FADE_STEPS - 1))
                                || (!fade_dir_reg && fade_step_reg == 5'h1)) begin
                                fade_state_reg <= gcs_pkg::FADE_HELD;
                            end
                        end else begin
                            fade_ms_reg <= fade_ms_reg + 1'b1;
                        end
                    end
                end
                default: fade_state_reg <= gcs_pkg::FADE_IDLE;
            endcase
        end
    end

    // with fading off the common value passes straight through
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fade_level <= 8'h00;
        end else if (!bank_en) begin
            fade_level <= 8'h00;
        end else if (fade_code == gcs_pkg::FADE_CODE_OFF) begin
            fade_level <= common_pwm;
        end else begin
            fade_level <= level_prod[11:4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power control

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pwm_en <= 1'b0;
            cc_en <= 1'b0;
            full_shutdown <= 1'b0;
            bank_wr_en <= 1'b0;
            bank_soft_reset <= 1'b0;
        end else begin
            // enable alone decides pwm_en and cc_en; key-scan sleep enters only full_shutdown
            pwm_en <= bank_en;
            cc_en <= bank_en;
            full_shutdown <= !bank_en && key_sleep_bit;
            bank_wr_en <= bank_en && !soft_rst;
            bank_soft_reset <= soft_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ports

    logic [PORTS-1:0] sensed;

    for (genvar p = 0; p < PORTS; p++) begin : g_dbnc
        gcs_debounce #(
            .DW(gcs_pkg::DEBOUNCE_W)
        ) u_dbnc (
            .clk_sys(clk_sys),
            .srst(srst),
            .ms_tick(ms_tick_reg),
            .sense_en(bank_en),
            .dbnc_ms(port_input_debounce_reg),
            .raw_in(general_input_pin[p]),
            .stable_out(sensed[p])
        );
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            general_output_pin <= '0;
            port_dir <= '0;
            port_in_value <= '0;
            rotary_mode <= 1'b0;
            rotary_input_a <= 1'b0;
            rotary_input_b <= 1'b0;
            port_interrupt_out <= 1'b0;
        end else begin
            port_dir <= port_direction_reg;
            // open-drain pull-down wherever an output is set low, enable or not
            general_output_pin <= port_direction_reg & ~port_out_level;
            port_in_value <= sensed & ~port_direction_reg;
            rotary_mode <= port_bank_global_config_reg.rotary;
            if (port_bank_global_config_reg.rotary) begin
                rotary_input_a <= sensed[PORTS-2];
                rotary_input_b <= sensed[PORTS-1];
                port_in_value[PORTS-1:PORTS-2] <= 2'h0;
            end else begin
                rotary_input_a <= 1'b0;
                rotary_input_b <= 1'b0;
            end
            port_interrupt_out <= timeout_flag_reg;
        end
    end
endmodule : gcs_port_bank

// >>> core/gcs_pkg.sv
// package: register map, field layout, reset values and timing of the port bank config
// What this block does
// - autosleep code 0 off, 1..6 give 8192..256 ms, 7 gives 256 ms, resets 7
// - rotary-select bit set makes the top two ports a rotary input pair
// - timeout interrupt enable set raises port interrupt on every bus timeout
// - reading the bus-timeout flag register releases the timeout interrupt
// - enable clear shuts down PWM, constant-current drive and input sensing
// - enable clear freezes registers 0x41 and 0x42 and ignores host writes to them; the 0x48 flag still sets and clears
// - enable clear leaves output pins following their own programmed settings
// - enable clear together with key-scan sleep shuts down the whole part
// - enable set keeps PWM, drive and all ports running even when key-scan sleeps
// - writing one to the reset bit returns registers 0x40..0x5F, all but the 0x48 bus-timeout flag, to power-on values
// - the reset bit clears itself and always reads back zero
// - fading ramps intensity between common PWM and zero in 16 equal steps
// - fade code 0 off, 1..5 give 256..4096 ms, 6 and 7 give 8192 and 16384 ms, resets 0
// - one direction bit per port, one is output, all ports reset to inputs
// - debounce register has reserved upper bits and a debounce time field below
// - global config resets to zero and its reserved bit always stays zero
package gcs_pkg;
    // register offsets
    localparam logic [7:0] OFS_KEY_SLEEP = 8'h06;
    localparam logic [7:0] OFS_GLOBAL = 8'h40;
    localparam logic [7:0] OFS_DIRECTION = 8'h41;
    localparam logic [7:0] OFS_DEBOUNCE = 8'h42;
    localparam logic [7:0] OFS_TIMEOUT_FLAG = 8'h48;
    localparam logic [7:0] OFS_BANK_LAST = 8'h5f;
    // reset values
    localparam logic [2:0] RST_SLEEP_CODE = 3'h7;
    localparam logic [7:0] RST_GLOBAL = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [4:0] RST_DEBOUNCE = 5'h00;
    // global config fields, then sleep code and debounce field widths
    localparam int BIT_ROTARY = 7;
    localparam int BIT_RSVD = 6;
    localparam int BIT_TO_INT_EN = 5;
    localparam int BIT_BANK_EN = 4;
    localparam int BIT_BANK_RESET = 3;
    localparam int SLEEP_CODE_W = 3;
    localparam int DEBOUNCE_W = 5;
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_PER_S = 1000;
    localparam int TICK_MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int SLEEP_MAX_MS = 8192;
    localparam int SLEEP_MIN_MS = 256;
    localparam int FADE_MIN_MS = 256;
    localparam int FADE_STEPS = 16;
    localparam int FADE_STEP_MIN_MS = FADE_MIN_MS / FADE_STEPS;
    localparam int MS_CNT_W = 14;
    localparam logic [2:0] SLEEP_CODE_OFF = 3'h0;
    localparam logic [2:0] SLEEP_CODE_MIN = 3'h6;
    localparam logic [2:0] FADE_CODE_OFF = 3'h0;

    typedef struct packed {
        logic rotary;
        logic rsvd;
        logic to_int_en;
        logic bank_en;
        logic bank_reset;
        logic [2:0] fade;
    } gcs_global_s;

    typedef enum logic [1:0] {
        FADE_IDLE = 2'h0,
        FADE_HELD = 2'h1,
        FADE_RAMP = 2'h3
    } gcs_fade_e;
endpackage : gcs_pkg

// >>> core/gcs_debounce.sv
// file: one input port debouncer counting millisecond ticks
`timescale 1ns/1ps
module gcs_debounce #(
    parameter int DW = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // control
    input wire logic ms_tick,
    input wire logic sense_en,
    input wire logic [DW-1:0] dbnc_ms,
    // pin
    input wire logic raw_in,
    output logic stable_out
);
    logic [DW-1:0] stab_cnt_reg;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stable_out <= 1'b0;
            stab_cnt_reg <= '0;
        end else if (!sense_en || raw_in == stable_out) begin
            stab_cnt_reg <= '0;
        end else if (dbnc_ms == '0) begin
            stable_out <= raw_in;
            stab_cnt_reg <= '0;
        end else if (ms_tick) begin
            // n ticks of unchanged level before acceptance
            if (stab_cnt_reg + 1'b1 >= dbnc_ms) begin
                stable_out <= raw_in;
                stab_cnt_reg <= '0;
            end else begin
                stab_cnt_reg <= stab_cnt_reg + 1'b1;
            end
        end
    end
endmodule : gcs_debounce

// >>> test/gcs_host_model.sv
// model: host side serial engine issuing single byte register accesses
`timescale 1ns/1ps
module gcs_host_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_hit
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // idle lines flip so a stale address or byte is never mistaken for a live one
    task automatic release_bus();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask : release_bus

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clk_sys);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        release_bus();
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic hit);
        @(negedge clk_sys);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge clk_sys);
        data = reg_rdata;
        hit = reg_rd_hit;
        release_bus();
    endtask : rd
endmodule : gcs_host_model

// >>> test/gcs_port_bank_checker.sv
// checker: concurrent assertions on the port bank config ports
`timescale 1ns/1ps
module gcs_port_bank_checker #(
    parameter int TICK_CYCLES = 10,
    parameter int PORTS = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_hit,
    // events and state
    input wire logic bus_timeout,
    input wire logic key_sleep_bit,
    input wire logic pwm_en,
    input wire logic cc_en,
    input wire logic full_shutdown,
    input wire logic bank_wr_en,
    input wire logic bank_soft_reset,
    input wire logic port_interrupt_out,
    // ports
    input wire logic [PORTS-1:0] port_dir,
    input wire logic [PORTS-1:0] general_output_pin,
    input wire logic [PORTS-1:0] port_in_value,
    input wire logic rotary_mode,
    input wire logic rotary_input_a,
    input wire logic rotary_input_b
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    read_hit_a: assert property (reg_rd |=> reg_rd_hit ==
        ($past(reg_addr) inside {8'h06, 8'h40, 8'h41, 8'h42})) else $error("bad read hit");
    sleep_rsvd_a: assert property (reg_rd && reg_addr == 8'h06 |=>
        reg_rdata[7:3] == 5'h00) else $error("sleep reserved bits set");
    global_rsvd_a: assert property (reg_rd && reg_addr == 8'h40 |=>
        !reg_rdata[6] && !reg_rdata[3]) else $error("global reserved or reset bit set");
    enable_pair_a: assert property (pwm_en == cc_en &&
        bank_wr_en == (pwm_en && !bank_soft_reset)) else $error("enable outputs disagree");
    full_shutdown_a: assert property ((!pwm_en && key_sleep_bit)[*3] |-> full_shutdown)
        else $error("no full shutdown");
    awake_no_shutdown_a: assert property (pwm_en[*2] |-> !full_shutdown)
        else $error("shutdown while enabled");
    soft_reset_a: assert property (reg_wr && reg_addr == 8'h40 && reg_wdata[3] |=>
        bank_soft_reset ##1 !bank_soft_reset) else $error("soft reset pulse wrong");
    irq_rise_a: assert property ($rose(port_interrupt_out) |-> $past(bus_timeout, 2))
        else $error("interrupt without timeout");
    irq_clear_a: assert property (reg_rd && reg_addr == 8'h48 && !bus_timeout |->
        ##2 !port_interrupt_out) else $error("interrupt not released");
    dir_out_a: assert property ($stable(port_dir) |->
        (general_output_pin & ~port_dir) == '0) else $error("input port driven");
    in_mask_a: assert property ($stable(port_dir) |->
        (port_in_value & port_dir) == '0) else $error("output port sensed");
    rotary_off_a: assert property (!rotary_mode && !$past(rotary_mode) |->
        !rotary_input_a && !rotary_input_b) else $error("rotary input outside rotary mode");
    rotary_on_a: assert property (rotary_mode && $past(rotary_mode) |->
        port_in_value[PORTS-1 -: 2] == 2'h0) else $error("rotary pins seen as inputs");
endmodule : gcs_port_bank_checker

bind gcs_port_bank gcs_port_bank_checker #(.TICK_CYCLES(TICK_CYCLES), .PORTS(PORTS)) chk (
    .clk_sys, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rd_hit,
    .bus_timeout, .key_sleep_bit, .pwm_en, .cc_en, .full_shutdown, .bank_wr_en,
    .bank_soft_reset, .port_interrupt_out, .port_dir, .general_output_pin, .port_in_value,
    .rotary_mode, .rotary_input_a, .rotary_input_b
);

// >>> test/gcs_port_bank_tb_top.sv
// testbench: register and port scenarios for the port bank config
`timescale 1ns/1ps
module gcs_port_bank_tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, common_pwm, fade_level;
    logic reg_wr, reg_rd, reg_rd_hit, bus_timeout, key_activity, key_sleep_bit, fade_up;
    logic pwm_en, cc_en, full_shutdown, key_sleep_req, bank_wr_en, bank_soft_reset;
    logic [7:0] general_input_pin, port_out_level, general_output_pin, port_dir, port_in_value;
    logic rotary_mode, rotary_input_a, rotary_input_b, port_interrupt_out;
    int fail_count = 0;
    int checks_done = 0;

    always #5 clk_sys = ~clk_sys;

    // one tick is 10 cycles so every ms figure scales by ten
    gcs_port_bank #(.TICK_CYCLES(10), .PORTS(8)) uut (
        .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit),
        .bus_timeout(bus_timeout), .key_activity(key_activity), .key_sleep_bit(key_sleep_bit),
        .common_pwm(common_pwm), .fade_up(fade_up), .fade_level(fade_level), .pwm_en(pwm_en),
        .cc_en(cc_en), .full_shutdown(full_shutdown), .key_sleep_req(key_sleep_req),
        .bank_wr_en(bank_wr_en), .bank_soft_reset(bank_soft_reset),
        .general_input_pin(general_input_pin), .port_out_level(port_out_level),
        .general_output_pin(general_output_pin), .port_dir(port_dir),
        .port_in_value(port_in_value), .rotary_mode(rotary_mode),
        .rotary_input_a(rotary_input_a), .rotary_input_b(rotary_input_b),
        .port_interrupt_out(port_interrupt_out)
    );

    gcs_host_model host (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit)
    );

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : wait_cyc

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input logic hit);
        logic [7:0] d;
        logic h;
        host.rd(addr, d, h);
        check(d, exp);
        check(8'(h), 8'(hit));
    endtask : rd_chk

    task automatic pulse(ref logic sig);
        @(negedge clk_sys);
        sig = 1'b1;
        @(negedge clk_sys);
        sig = 1'b0;
    endtask : pulse

    // idle limit: asleep just after the period, awake just before it
    task automatic sleep_chk(input logic [7:0] code, input int ms);
        host.wr(8'h06, code);
        pulse(key_activity);
        wait_cyc(3);
        check(8'(key_sleep_req), 8'h00);
        wait_cyc(ms * 10 - 160);
        check(8'(key_sleep_req), 8'h00);
        wait_cyc(300);
        check(8'(key_sleep_req), (code == 8'h00) ? 8'h00 : 8'h01);
    endtask : sleep_chk

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        print_verdict();
    end

    initial begin
        {bus_timeout, key_activity, key_sleep_bit, fade_up} = 4'h1;
        common_pwm = 8'h80;
        general_input_pin = 8'h00;
        port_out_level = 8'ha5;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        rd_chk(8'h06, 8'h07, 1'b1);
        rd_chk(8'h40, 8'h00, 1'b1);
        rd_chk(8'h41, 8'h00, 1'b1);
        rd_chk(8'h42, 8'h00, 1'b1);
        rd_chk(8'h30, 8'h00, 1'b0);
        sleep_chk(8'h07, 256);
        sleep_chk(8'h05, 512);
        sleep_chk(8'h06, 256);
        sleep_chk(8'h00, 256);
        host.wr(8'h06, 8'hff);
        rd_chk(8'h06, 8'h07, 1'b1);
        // bank disabled: config frozen, whole part down once key-scan sleeps
        host.wr(8'h41, 8'hff);
        rd_chk(8'h41, 8'h00, 1'b1);
        host.wr(8'h42, 8'h03);
        rd_chk(8'h42, 8'h00, 1'b1);
        key_sleep_bit = 1'b1;
        wait_cyc(3);
        check(8'(full_shutdown), 8'h01);
        check(8'(pwm_en), 8'h00);
        host.wr(8'h40, 8'h10);
        wait_cyc(2);
        check({6'h00, pwm_en, cc_en}, 8'h03);
        check(8'(full_shutdown), 8'h00);
        key_sleep_bit = 1'b0;
        host.wr(8'h40, 8'hf7);
        rd_chk(8'h40, 8'hb7, 1'b1);
        host.wr(8'h42, 8'hff);
        rd_chk(8'h42, 8'h1f, 1'b1);
        host.wr(8'h41, 8'h0f);
        wait_cyc(2);
        check(port_dir, 8'h0f);
        check(general_output_pin, 8'h0a);
        // bus timeout interrupt with enable set, then with it clear
        pulse(bus_timeout);
        wait_cyc(3);
        check(8'(port_interrupt_out), 8'h01);
        rd_chk(8'h48, 8'h00, 1'b0);
        wait_cyc(2);
        check(8'(port_interrupt_out), 8'h00);
        host.wr(8'h40, 8'h10);
        pulse(bus_timeout);
        wait_cyc(3);
        check(8'(port_interrupt_out), 8'h00);
        // 3 ms debounce on an input port, then rotary takes the top pair
        host.wr(8'h42, 8'h03);
        general_input_pin = 8'h10;
        wait_cyc(15);
        check(port_in_value, 8'h00);
        wait_cyc(35);
        check(port_in_value, 8'h10);
        host.wr(8'h40, 8'h90);
        general_input_pin = 8'hd0;
        wait_cyc(60);
        check(port_in_value, 8'h10);
        check({6'h00, rotary_input_a, rotary_input_b}, 8'h03);
        // 256 ms fade down to zero and back up to the common value
        host.wr(8'h40, 8'h11);
        fade_up = 1'b0;
        wait_cyc(2700);
        check(fade_level, 8'h00);
        fade_up = 1'b1;
        wait_cyc(2700);
        check(fade_level, 8'h80);
        // bank off: outputs keep their programmed pull-downs, intensity drops
        host.wr(8'h40, 8'h00);
        wait_cyc(2);
        check(general_output_pin, 8'h0a);
        check(fade_level, 8'h00);
        host.wr(8'h40, 8'h18);
        check(8'(bank_soft_reset), 8'h01);
        rd_chk(8'h40, 8'h00, 1'b1);
        rd_chk(8'h41, 8'h00, 1'b1);
        rd_chk(8'h42, 8'h00, 1'b1);
        print_verdict();
    end
endmodule : gcs_port_bank_tb_top
